// ===== logic/servo_gain_map.vh
`ifndef SERVO_GAIN_MAP_VH
`define SERVO_GAIN_MAP_VH
// register byte offsets
`define OFS_VEL_PROP_GAIN      12'h000
`define OFS_VEL_INT_GAIN       12'h004
`define OFS_POS_PROP_GAIN      12'h008
`define OFS_VEL_PROP_STEP      12'h00c
`define OFS_VEL_INT_STEP       12'h010
`define OFS_POS_PROP_STEP      12'h014
`define OFS_INPOS_TOL          12'h018
`define OFS_PEAK_LIMIT         12'h01c
`define OFS_RMS_LIMIT          12'h020
`define OFS_RMS_TIMEOUT        12'h024
`define OFS_CONTROL            12'h040
`define OFS_STATUS             12'h044
`define OFS_IRQ_STATUS         12'h048
`define OFS_IRQ_MASK           12'h04c
`define OFS_ACTIVE_LIMITS      12'h050
// reset values
`define RST_VEL_PROP_GAIN      32'h000b_71b0
`define RST_VEL_INT_GAIN       32'h0000_88b8
`define RST_POS_PROP_GAIN      32'h0000_3a98
`define RST_VEL_PROP_STEP      32'h0000_03e8
`define RST_VEL_INT_STEP       32'h0000_0064
`define RST_POS_PROP_STEP      32'h0000_000a
`define RST_INPOS_TOL          32'h0000_0002
`define RST_PEAK_LIMIT         32'h0000_0064
`define RST_RMS_LIMIT          32'h0000_0014
`define RST_RMS_TIMEOUT        32'h0000_0002
// ranges
`define GAIN_MAX               32'h7fff_ffff
`define STEP_MAX               32'h0001_86a0
`define TOL_MIN                32'h0000_0001
`define TOL_MAX                32'h0000_03e8
`define PCT_MAX                32'h0000_0064
`define TIMEOUT_MAX            32'h0000_000a
// control bits
`define CTL_INPOS_OUT_SEL      0
`define CTL_RELOAD             1
`define CTL_FAULT_CLR          2
// irq bits
`define IRQ_INPOS_RISE         0
`define IRQ_RMS_FAULT          1
`define IRQ_SAVE               2
// isolated output bit for in-position
`define ISO_INPOS_BIT          2
// timing: one second at 50 MHz
`define CLK_HZ                 50000000
`define SECOND_NS              1000000000
`define CLK_NS                 20
`endif

// ===== logic/servo_gain_regs.v
// Overview of operation
// [RULE1] velocity proportional gain, reset 750000, max 2^31-1
// [RULE2] velocity integral gain, reset 35000
// [RULE3] position proportional gain, reset 15000
// [RULE4] velocity prop step add/sub, reset 1000
// [RULE5] velocity integral step add/sub, reset 100
// [RULE6] position prop step add/sub, reset 10
// [RULE7] stepped gain drives loop immediately
// [RULE8] confirm writes gain to nonvolatile store
// [RULE9] status bit0 while error within tolerance
// [RULE10] iso output bit2 when option selected
// [RULE11] clamp current command to peak percent
// [RULE12] peak limit, timeout active after reset; the code applies written values only on a CONTROL reload write
// [RULE13] rms threshold percent of rating, reset 20
// [RULE14] fault after rms over for timeout
// [RULE15] stepped gains saturate, never wrap
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "servo_gain_map.vh"
module servo_gain_regs #(
  parameter [31:0] CYCLES_PER_SEC = `SECOND_NS / `CLK_NS
) (
  input  wire        i_clk_sys,
  input  wire        i_rst_n,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output wire        o_pready,
  output reg  [31:0] o_prdata,
  output wire        o_pslverr,
  input  wire [1:0]  i_step_gain_sel,
  input  wire        i_step_up,
  input  wire        i_step_down,
  input  wire        i_step_confirm,
  input  wire [31:0] i_position_error,
  input  wire [31:0] i_current_cmd,
  input  wire [31:0] i_rms_current,
  input  wire [31:0] i_peak_rating,
  input  wire [31:0] i_rms_rating,
  output reg  [31:0] o_velocity_prop_gain,
  output reg  [31:0] o_velocity_integral_gain,
  output reg  [31:0] o_position_prop_gain,
  output reg  [31:0] o_current_cmd_clamped,
  output reg         o_in_position,
  output reg  [2:0]  o_iso_out,
  output reg         o_rms_fault,
  output reg         o_nv_save,
  output reg  [1:0]  o_nv_save_sel,
  output reg  [31:0] o_nv_save_data,
  output wire        o_irq
);
  reg  [31:0] vp_step_reg;
  reg  [31:0] vi_step_reg;
  reg  [31:0] pp_step_reg;
  reg  [31:0] tol_reg;
  reg  [31:0] peak_reg;
  reg  [31:0] rms_lim_reg;
  reg  [31:0] timeout_reg;
  reg  [31:0] peak_act_reg;
  reg  [31:0] timeout_act_reg;
  reg         sel_reg;
  reg  [2:0]  irq_st_reg;
  reg  [2:0]  irq_mask_reg;
  reg  [31:0] sec_cnt_reg;
  reg  [3:0]  over_sec_reg;
  reg         inpos_d_reg;
  reg  [31:0] gain_sel_cur;
  reg  [31:0] step_sel_cur;
  reg  [31:0] gain_next;
  reg  [32:0] sum;
  reg  [31:0] abs_err;
  reg  [63:0] peak_prod;
  reg  [63:0] rms_prod;
  reg  [31:0] peak_amp;
  reg  [31:0] rms_amp;
  reg  [2:0]  irq_set;

  wire acc  = i_psel & i_penable;
  wire wr   = acc & i_pwrite;
  wire step = i_step_up ^ i_step_down;
  wire hit_w = wr & (i_paddr == `OFS_CONTROL);

  assign o_pready  = 1'b1;
  assign o_pslverr = 1'b0;
  assign o_irq     = |(irq_st_reg & irq_mask_reg);

  function [31:0] clip;
    input [31:0] v;
    input [31:0] lo;
    input [31:0] hi;
    begin
      clip = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction

  always @* begin
    case (i_step_gain_sel)
      2'd0: begin
        gain_sel_cur = o_velocity_prop_gain;
        step_sel_cur = vp_step_reg;
      end
      2'd1: begin
        gain_sel_cur = o_velocity_integral_gain;
        step_sel_cur = vi_step_reg;
      end
      default: begin
        gain_sel_cur = o_position_prop_gain;
        step_sel_cur = pp_step_reg;
      end
    endcase
    sum = 33'h0_0000_0000;
    if (i_step_up) begin
      sum = {1'b0, gain_sel_cur} + {1'b0, step_sel_cur};
      gain_next = (sum > {1'b0, `GAIN_MAX}) ? `GAIN_MAX : sum[31:0];  // [RULE15]
    end else begin
      gain_next = (gain_sel_cur < step_sel_cur) ? 32'h0000_0000
                                                : gain_sel_cur - step_sel_cur; // [RULE15]
    end
    abs_err   = i_position_error[31] ? (~i_position_error + 32'h0000_0001)
                                     : i_position_error;
    peak_prod = i_peak_rating * peak_act_reg;
    rms_prod  = i_rms_rating * rms_lim_reg;
    peak_amp  = peak_prod[63:32] != 32'h0000_0000 ? 32'hffff_ffff
                                                   : peak_prod[31:0] / `PCT_MAX;
    rms_amp   = rms_prod[63:32] != 32'h0000_0000 ? 32'hffff_ffff
                                                 : rms_prod[31:0] / `PCT_MAX;
  end

  // gains and steps: bus writes clipped to range, step keys add or subtract
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_velocity_prop_gain     <= `RST_VEL_PROP_GAIN;  // [RULE1]
      o_velocity_integral_gain <= `RST_VEL_INT_GAIN;   // [RULE2]
      o_position_prop_gain     <= `RST_POS_PROP_GAIN;  // [RULE3]
      vp_step_reg              <= `RST_VEL_PROP_STEP;  // [RULE4]
      vi_step_reg              <= `RST_VEL_INT_STEP;   // [RULE5]
      pp_step_reg              <= `RST_POS_PROP_STEP;  // [RULE6]
      tol_reg                  <= `RST_INPOS_TOL;
      peak_reg                 <= `RST_PEAK_LIMIT;
      rms_lim_reg              <= `RST_RMS_LIMIT;      // [RULE13]
      timeout_reg              <= `RST_RMS_TIMEOUT;
      peak_act_reg             <= `RST_PEAK_LIMIT;
      timeout_act_reg          <= `RST_RMS_TIMEOUT;
      sel_reg                  <= 1'b0;
      irq_mask_reg             <= 3'h0;
      o_nv_save                <= 1'b0;
      o_nv_save_sel            <= 2'h0;
      o_nv_save_data           <= 32'h0000_0000;
    end else begin
      o_nv_save <= 1'b0;
      if (step && i_step_gain_sel != 2'd3) begin
        // takes effect on the loop outputs next cycle
        case (i_step_gain_sel)
          2'd0: o_velocity_prop_gain     <= gain_next; // [RULE4] [RULE7]
          2'd1: o_velocity_integral_gain <= gain_next; // [RULE5] [RULE7]
          default: o_position_prop_gain  <= gain_next; // [RULE6] [RULE7]
        endcase
      end else if (wr) begin
        case (i_paddr)
          `OFS_VEL_PROP_GAIN: o_velocity_prop_gain     <= clip(i_pwdata, 32'h0, `GAIN_MAX);
          `OFS_VEL_INT_GAIN:  o_velocity_integral_gain <= clip(i_pwdata, 32'h0, `GAIN_MAX);
          `OFS_POS_PROP_GAIN: o_position_prop_gain     <= clip(i_pwdata, 32'h0, `GAIN_MAX);
          `OFS_VEL_PROP_STEP: vp_step_reg  <= clip(i_pwdata, 32'h0, `STEP_MAX);
          `OFS_VEL_INT_STEP:  vi_step_reg  <= clip(i_pwdata, 32'h0, `STEP_MAX);
          `OFS_POS_PROP_STEP: pp_step_reg  <= clip(i_pwdata, 32'h0, `STEP_MAX);
          `OFS_INPOS_TOL:     tol_reg      <= clip(i_pwdata, `TOL_MIN, `TOL_MAX);
          `OFS_PEAK_LIMIT:    peak_reg     <= clip(i_pwdata, 32'h0, `PCT_MAX);
          `OFS_RMS_LIMIT:     rms_lim_reg  <= clip(i_pwdata, 32'h0, `PCT_MAX);
          `OFS_RMS_TIMEOUT:   timeout_reg  <= clip(i_pwdata, 32'h0, `TIMEOUT_MAX);
          `OFS_IRQ_MASK:      irq_mask_reg <= i_pwdata[2:0];
          `OFS_CONTROL:       sel_reg      <= i_pwdata[`CTL_INPOS_OUT_SEL];
          default: ;
        endcase
      end
      // written peak limit and rms timeout are latched only by a controller reload; the rms limit applies at once
      if (hit_w && i_pwdata[`CTL_RELOAD]) begin
        peak_act_reg    <= peak_reg;    // [RULE12]
        timeout_act_reg <= timeout_reg; // [RULE12]
      end
      if (i_step_confirm && i_step_gain_sel != 2'd3) begin
        o_nv_save     <= 1'b1;          // [RULE8]
        o_nv_save_sel <= i_step_gain_sel;
        o_nv_save_data <= gain_sel_cur; // [RULE8]
      end
    end
  end

  // in-position, clamp and rms supervision
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_in_position         <= 1'b0;
      inpos_d_reg           <= 1'b0;
      o_iso_out             <= 3'h0;
      o_current_cmd_clamped <= 32'h0000_0000;
      o_rms_fault           <= 1'b0;
      sec_cnt_reg           <= 32'h0000_0000;
      over_sec_reg          <= 4'h0;
    end else begin
      o_in_position <= (abs_err <= tol_reg);                                // [RULE9]
      inpos_d_reg   <= o_in_position;
      o_iso_out     <= {sel_reg & o_in_position, 2'b00};                    // [RULE10]
      if (!i_current_cmd[31] && i_current_cmd > peak_amp)
        o_current_cmd_clamped <= peak_amp;                                  // [RULE11]
      else if (i_current_cmd[31] && (~i_current_cmd + 32'h0000_0001) > peak_amp)
        o_current_cmd_clamped <= ~peak_amp + 32'h0000_0001;                 // [RULE11]
      else
        o_current_cmd_clamped <= i_current_cmd;
      if (i_rms_current > rms_amp) begin                                    // [RULE13]
        // resolution of one second; a zero timeout faults at once
        if ({28'h0, over_sec_reg} >= timeout_act_reg)
          o_rms_fault <= 1'b1;                                              // [RULE14]
        if (sec_cnt_reg == CYCLES_PER_SEC - 32'h0000_0001) begin
          sec_cnt_reg <= 32'h0000_0000;
          if (over_sec_reg != 4'hf)
            over_sec_reg <= over_sec_reg + 4'h1;
        end else begin
          sec_cnt_reg <= sec_cnt_reg + 32'h0000_0001;
        end
      end else begin
        sec_cnt_reg  <= 32'h0000_0000;
        over_sec_reg <= 4'h0;
      end
      if (hit_w && i_pwdata[`CTL_FAULT_CLR] && !(i_rms_current > rms_amp))
        o_rms_fault <= 1'b0;
    end
  end

  // sticky events; a new event wins over a clear in the same cycle
  always @* begin
    irq_set = 3'h0;
    irq_set[`IRQ_INPOS_RISE] = o_in_position & ~inpos_d_reg;
    irq_set[`IRQ_RMS_FAULT]  = o_rms_fault;
    irq_set[`IRQ_SAVE]       = o_nv_save;
  end

  // one sticky flag per event; the set branch comes first so a clear never hides a new event
  genvar b;
  generate
    for (b = 0; b < 3; b = b + 1) begin : g_irq
      always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
          irq_st_reg[b] <= 1'b0;
        end else if (irq_set[b]) begin
          irq_st_reg[b] <= 1'b1;
        end else if (wr && i_paddr == `OFS_IRQ_STATUS && i_pwdata[b]) begin
          irq_st_reg[b] <= 1'b0;
        end
      end
    end
  endgenerate

  always @* begin
    case (i_paddr)
      `OFS_VEL_PROP_GAIN: o_prdata = o_velocity_prop_gain;
      `OFS_VEL_INT_GAIN:  o_prdata = o_velocity_integral_gain;
      `OFS_POS_PROP_GAIN: o_prdata = o_position_prop_gain;
      `OFS_VEL_PROP_STEP: o_prdata = vp_step_reg;
      `OFS_VEL_INT_STEP:  o_prdata = vi_step_reg;
      `OFS_POS_PROP_STEP: o_prdata = pp_step_reg;
      `OFS_INPOS_TOL:     o_prdata = tol_reg;
      `OFS_PEAK_LIMIT:    o_prdata = peak_reg;
      `OFS_RMS_LIMIT:     o_prdata = rms_lim_reg;
      `OFS_RMS_TIMEOUT:   o_prdata = timeout_reg;
      `OFS_CONTROL:       o_prdata = {31'h0, sel_reg};
      `OFS_STATUS:        o_prdata = {30'h0, o_rms_fault, o_in_position};  // [RULE9]
      `OFS_IRQ_STATUS:    o_prdata = {29'h0, irq_st_reg};
      `OFS_IRQ_MASK:      o_prdata = {29'h0, irq_mask_reg};
      `OFS_ACTIVE_LIMITS: o_prdata = {timeout_act_reg[15:0], peak_act_reg[15:0]};
      default:            o_prdata = 32'h0000_0000;
    endcase
  end
endmodule

// ===== testbench/servo_gain_regs_monitor.sv
`timescale 1ns/1ps
module servo_gain_regs_monitor (
  input wire        i_clk_sys,
  input wire        i_rst_n,
  input wire        i_psel,
  input wire        i_penable,
  input wire        i_pwrite,
  input wire [1:0]  i_step_gain_sel,
  input wire        i_step_up,
  input wire        i_step_down,
  input wire        i_step_confirm,
  input wire [31:0] i_position_error,
  input wire [31:0] i_peak_rating,
  input wire [31:0] i_rms_current,
  input wire [31:0] o_velocity_prop_gain,
  input wire [31:0] o_velocity_integral_gain,
  input wire [31:0] o_position_prop_gain,
  input wire [31:0] o_current_cmd_clamped,
  input wire        o_in_position,
  input wire [2:0]  o_iso_out,
  input wire        o_rms_fault,
  input wire [31:0] o_nv_save_data,
  input wire        o_nv_save
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  wire        wr  = i_psel && i_penable && i_pwrite;
  wire        one = i_step_up ^ i_step_down;
  wire [31:0] mag = o_current_cmd_clamped[31] ? -o_current_cmd_clamped : o_current_cmd_clamped;
  a_vp_step_up: assert property (one && i_step_up && i_step_gain_sel == 2'd0
    |=> o_velocity_prop_gain >= $past(o_velocity_prop_gain)) else $error("vp step up");
  a_vi_step_down: assert property (one && i_step_down && i_step_gain_sel == 2'd1
    |=> o_velocity_integral_gain <= $past(o_velocity_integral_gain)) else $error("vi step");
  a_pp_step_up: assert property (one && i_step_up && i_step_gain_sel == 2'd2
    |=> o_position_prop_gain >= $past(o_position_prop_gain)) else $error("pp step up");
  a_gain_in_range: assert property (!o_velocity_prop_gain[31] &&
    !o_velocity_integral_gain[31] && !o_position_prop_gain[31]) else $error("gain range");
  a_gain_hold_idle: assert property (!one && !wr |=> $stable(o_velocity_prop_gain) &&
    $stable(o_velocity_integral_gain) && $stable(o_position_prop_gain)) else $error("gain moved");
  a_save_value: assert property (i_step_confirm && i_step_gain_sel == 2'd0 && !one && !wr
    |=> o_nv_save && o_nv_save_data == o_velocity_prop_gain) else $error("save value");
  a_inpos_zero_err: assert property (i_position_error == 32'h0000_0000
    |=> o_in_position) else $error("in position missing");
  a_iso_after_inpos: assert property (o_iso_out[2] |-> $past(o_in_position))
    else $error("iso without in position");
  a_clamp_peak: assert property (mag <= $past(i_peak_rating)) else $error("clamp");
  a_fault_sticky: assert property (o_rms_fault && !wr |=> o_rms_fault)
    else $error("fault dropped");
  a_fault_cause: assert property ($rose(o_rms_fault) |-> $past(i_rms_current) != 0)
    else $error("fault without current");
endmodule
bind servo_gain_regs servo_gain_regs_monitor servo_gain_regs_monitor_inst (.*);

// ===== testbench/servo_gain_regs_tb_top.sv
`timescale 1ns/1ps
`include "servo_gain_map.vh"
module servo_gain_regs_tb_top;
  logic        i_clk_sys, i_rst_n, i_psel, i_penable, i_pwrite;
  logic        i_step_up, i_step_down, i_step_confirm;
  logic [1:0]  i_step_gain_sel;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, err_set, cmd_set, rms_set, q, g, s;
  wire         o_pready, o_pslverr, o_in_position, o_rms_fault, o_nv_save, o_irq;
  wire  [1:0]  o_nv_save_sel;
  wire  [2:0]  o_iso_out;
  wire  [31:0] o_prdata, o_velocity_prop_gain, o_velocity_integral_gain, o_position_prop_gain;
  wire  [31:0] o_current_cmd_clamped, o_nv_save_data, i_position_error, i_current_cmd;
  wire  [31:0] i_rms_current, i_peak_rating, i_rms_rating;
  int          bad_count = 0;
  int          n_compared = 0;
  int          n;
  logic [31:0] rst_tab [10] = '{`RST_VEL_PROP_GAIN, `RST_VEL_INT_GAIN, `RST_POS_PROP_GAIN,
    `RST_VEL_PROP_STEP, `RST_VEL_INT_STEP, `RST_POS_PROP_STEP, `RST_INPOS_TOL,
    `RST_PEAK_LIMIT, `RST_RMS_LIMIT, `RST_RMS_TIMEOUT};

  // ten cycles per second keeps the rms timeout short
  servo_gain_regs #(.CYCLES_PER_SEC(32'd10)) servo_gain_regs_inst (.*);
  servo_power_model servo_power_model_inst (.i_clk_sys(i_clk_sys), .i_err_set(err_set),
    .i_cmd_set(cmd_set), .i_rms_set(rms_set), .o_position_error(i_position_error),
    .o_current_cmd(i_current_cmd), .o_rms_current(i_rms_current),
    .o_peak_rating(i_peak_rating), .o_rms_rating(i_rms_rating));

  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end

  task automatic stop_test;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // read data lands in q at the edge that samples pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    do @(posedge i_clk_sys); while (o_pready !== 1'b1);
    q = o_prdata;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk_sys);
  endtask

  task automatic step(input logic [1:0] k, input logic up);
    i_step_gain_sel <= k;
    i_step_up <= up;
    i_step_down <= !up;
    @(posedge i_clk_sys);
    i_step_up <= 1'b0;
    i_step_down <= 1'b0;
    @(posedge i_clk_sys);
  endtask

  function automatic logic [31:0] step_exp(input logic [31:0] v, input logic [31:0] d,
                                            input logic up);
    if (up) return (v + d > `GAIN_MAX) ? `GAIN_MAX : v + d;
    return (v < d) ? 32'h0000_0000 : v - d;
  endfunction

  function automatic logic [31:0] gain_of(input int k);
    if (k == 0) return o_velocity_prop_gain;
    if (k == 1) return o_velocity_integral_gain;
    return o_position_prop_gain;
  endfunction

  initial begin
    repeat (5000) @(posedge i_clk_sys);
    bad_count++;
    stop_test;
  end

  initial begin
    n = $urandom(39915);
    {i_psel, i_penable, i_pwrite, i_step_up, i_step_down, i_step_confirm} = '0;
    i_step_gain_sel = 2'd3;
    i_paddr = '0;
    i_pwdata = '0;
    err_set = 32'h0000_0064;
    cmd_set = '0;
    rms_set = '0;
    i_rst_n = 1'b0;
    repeat (10) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      apb(1'b0, 12'(4 * i), '0);
      chk(q, rst_tab[i]);
    end
    chk({31'h0, o_pslverr}, 32'h0000_0000);
    apb(1'b1, 12'h0fc, 32'hffff_ffff);
    apb(1'b0, 12'h0fc, '0);
    chk(q, 32'h0000_0000);
    apb(1'b1, `OFS_VEL_PROP_GAIN, 32'hffff_ffff);
    apb(1'b0, `OFS_VEL_PROP_GAIN, '0);
    chk(q, `GAIN_MAX);
    for (int k = 0; k < 3; k++) begin
      s = $urandom_range(100000, 1);
      g = $urandom_range(200000, 0);
      apb(1'b1, 12'(4 * k), g);
      apb(1'b1, 12'(4 * k + 12), s);
      repeat (4) begin
        n = $urandom_range(1, 0);
        step(2'(k), n[0]);
        g = step_exp(g, s, n[0]);
        chk(gain_of(k), g);
      end
      apb(1'b1, 12'(4 * k), `GAIN_MAX - 2);
      step(2'(k), 1'b1);
      chk(gain_of(k), `GAIN_MAX);
    end
    i_step_gain_sel <= 2'd0;
    i_step_confirm <= 1'b1;
    @(posedge i_clk_sys);
    i_step_confirm <= 1'b0;
    #1;
    chk(o_nv_save, 1'b1);
    chk(o_nv_save_data, `GAIN_MAX);
    chk({30'h0, o_nv_save_sel}, 32'h0000_0000);
    s = $urandom_range(1000, 1);
    apb(1'b1, `OFS_INPOS_TOL, s);
    apb(1'b1, `OFS_CONTROL, 32'h0000_0001);
    apb(1'b1, `OFS_IRQ_MASK, 32'h0000_0001);
    err_set <= s;
    repeat (4) @(posedge i_clk_sys);
    chk(o_in_position, 1'b1);
    chk(o_iso_out[2], 1'b1);
    chk(o_irq, 1'b1);
    err_set <= -s - 1;
    repeat (4) @(posedge i_clk_sys);
    chk(o_in_position, 1'b0);
    apb(1'b1, `OFS_IRQ_STATUS, 32'h0000_0007);
    chk(o_irq, 1'b0);
    cmd_set <= 32'h0000_000f;
    repeat (4) @(posedge i_clk_sys);
    chk(o_current_cmd_clamped, 32'h0000_000f);
    apb(1'b1, `OFS_PEAK_LIMIT, 32'h0000_0032);
    chk(o_current_cmd_clamped, 32'h0000_000f);
    apb(1'b1, `OFS_CONTROL, 32'h0000_0003);
    cmd_set <= 32'hffff_fff1;
    repeat (4) @(posedge i_clk_sys);
    chk(o_current_cmd_clamped, 32'hffff_fff6);
    apb(1'b0, `OFS_ACTIVE_LIMITS, '0);
    chk(q, 32'h0002_0032);
    apb(1'b1, `OFS_RMS_LIMIT, 32'h0000_0032);
    rms_set <= 32'h0000_0005;
    repeat (60) @(posedge i_clk_sys);
    chk(o_rms_fault, 1'b0);
    rms_set <= 32'h0000_0006;
    repeat (8) @(posedge i_clk_sys);
    chk(o_rms_fault, 1'b0);
    repeat (30) @(posedge i_clk_sys);
    chk(o_rms_fault, 1'b1);
    rms_set <= '0;
    repeat (3) @(posedge i_clk_sys);
    apb(1'b1, `OFS_CONTROL, 32'h0000_0004);
    chk(o_rms_fault, 1'b0);
    stop_test;
  end
endmodule

// ===== testbench/servo_power_model.sv
`timescale 1ns/1ps
module servo_power_model #(
  parameter [31:0] PEAK_AMPS = 32'h0000_0014,
  parameter [31:0] RMS_AMPS  = 32'h0000_000a
) (
  input  wire        i_clk_sys,
  input  wire [31:0] i_err_set,
  input  wire [31:0] i_cmd_set,
  input  wire [31:0] i_rms_set,
  output reg  [31:0] o_position_error = 32'h0000_0000,
  output reg  [31:0] o_current_cmd    = 32'h0000_0000,
  output reg  [31:0] o_rms_current    = 32'h0000_0000,
  output wire [31:0] o_peak_rating,
  output wire [31:0] o_rms_rating
);
  // ratings are fixed by the stage build; sensed values lag one sample like a real adc
  assign o_peak_rating = PEAK_AMPS;
  assign o_rms_rating  = RMS_AMPS;
  always @(posedge i_clk_sys) begin
    o_position_error <= i_err_set;
    o_current_cmd    <= i_cmd_set;
    o_rms_current    <= i_rms_set;
  end
endmodule
